/* hdl/tli_pkg.sv */
// Constants, register map and a helper function for the two-level interrupt handler
//
// Behaviour
// - A source event sets that source's pending flag to one.
// - A request needs pending flag, global enable and the source's own enable.
// - A granted request waits for the current instruction, then forces a long call.
// - Return-from-interrupt resumes the program and closes the current nesting level.
// - Pending flags set regardless of enables; disabled flags cause no request.
// - Some flags clear automatically on vectoring; others software must clear.
// - A flag still set after return re-enters after exactly one more instruction.
// - Each source has an enable bit, honoured only while bit 7 global enable is set.
// - Global enable at zero blocks every source whatever its own enable.
// - Events during global disable stay pending and are served once re-enabled.
// - Software writing one to a pending flag acts exactly like a hardware event.
// - Each source has a priority bit choosing low or high level.
// - A high-priority request pre-empts a running low-priority routine.
// - While a high-priority routine runs, nothing further is accepted.
// - After a pre-empting high routine returns, the low routine resumes and completes.
// - All priority bits reset to low.
// - Among simultaneous requests, high priority is granted before low.
// - Equal-priority simultaneous requests are chosen by a fixed source order.
// - Requests are sampled and priority decoded every clock cycle.
// - Behind an equal or higher routine, a request waits for return plus one instruction.
package tli_pkg;

	localparam int          MAX_SRC      = 32;
	localparam int          IDX_W        = 5;
	localparam int          NUM_SRC      = 23;
	localparam int          LOW_EN_BITS  = 7;
	localparam int          GLOBAL_EN_BIT = 7;

	// Register offsets on the plain register port
	localparam logic [7:0]  OFS_ENABLE   = 8'h00;
	localparam logic [7:0]  OFS_EXT_EN   = 8'h04;
	localparam logic [7:0]  OFS_PRIO     = 8'h08;
	localparam logic [7:0]  OFS_EXT_PRIO = 8'h0c;
	localparam logic [7:0]  OFS_PENDING  = 8'h10;
	localparam logic [7:0]  OFS_STATUS   = 8'h14;

	// Status register fields
	localparam int          ST_ISR_LOW   = 0;
	localparam int          ST_ISR_HIGH  = 1;
	localparam int          ST_REQ       = 2;
	localparam int          ST_SRC_LSB   = 8;

	// Reset values
	localparam logic [31:0] RST_MASK     = 32'h0000_0000;
	localparam logic        RST_BIT      = 1'b0;

	// Vector layout and sources whose flag is cleared on vectoring
	localparam logic [15:0] VEC_BASE     = 16'h0003;
	localparam logic [15:0] VEC_STEP     = 16'h0008;
	localparam logic [31:0] AUTO_CLR     = 32'h0000_000f;

	// Identity arbitration order: rank r holds source r
	function automatic logic [MAX_SRC*IDX_W-1:0] identity_order();
		logic [MAX_SRC*IDX_W-1:0] o;
		o = '0;
		for (int r = 0; r < MAX_SRC; r++) begin
			o[r*IDX_W +: IDX_W] = IDX_W'(r);
		end
		return o;
	endfunction : identity_order

endpackage : tli_pkg

/* hdl/tli_arb_if.sv */
// Interface between the handler core and its priority arbiter
`timescale 1ns/100ps
`default_nettype none
interface tli_arb_if #(parameter int N = tli_pkg::NUM_SRC);
	logic [N-1:0]              elig;
	logic [N-1:0]              high;
	logic                      found;
	logic                      win_high;
	logic [tli_pkg::IDX_W-1:0] idx;

	modport arb (input elig, input high, output found, output win_high, output idx);
	modport ctl (output elig, output high, input found, input win_high, input idx);
endinterface : tli_arb_if
`default_nettype wire

/* hdl/tli_arbiter.sv */
// Two-level fixed-order priority arbiter
`timescale 1ns/100ps
`default_nettype none
module tli_arbiter #(
	parameter int                                                N     = tli_pkg::NUM_SRC,
	parameter logic [tli_pkg::MAX_SRC*tli_pkg::IDX_W-1:0] ORDER = tli_pkg::identity_order()
) (
	// Arbitration request and result
	tli_arb_if.arb a
);

	////////////////////////////////////////////////////////////////////////////////
	// Scan ranks from last to first so the last rank found, the lowest, is the one kept
	always_comb begin
		logic [tli_pkg::IDX_W-1:0] s;
		logic                      hit_h;
		logic                      hit_l;
		logic [tli_pkg::IDX_W-1:0] idx_h;
		logic [tli_pkg::IDX_W-1:0] idx_l;
		s     = '0;
		hit_h = 1'b0;
		hit_l = 1'b0;
		idx_h = '0;
		idx_l = '0;
		for (int r = N - 1; r >= 0; r--) begin
			s = ORDER[r*tli_pkg::IDX_W +: tli_pkg::IDX_W];
			if (int'(s) < N && a.elig[s]) begin
				if (a.high[s]) begin
					hit_h = 1'b1;
					idx_h = s;
				end else begin
					hit_l = 1'b1;
					idx_l = s;
				end
			end
		end
		// High level always beats low level
		a.found    = hit_h | hit_l;
		a.win_high = hit_h;
		a.idx      = hit_h ? idx_h : idx_l;
	end

endmodule : tli_arbiter
`default_nettype wire

/* hdl/tli_handler.sv */
// Two-level interrupt handler: flags, enables, priorities, nesting and vectoring
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tli_handler #(
	parameter int                                                N         = tli_pkg::NUM_SRC,
	parameter logic [15:0]                                       VEC_BASE  = tli_pkg::VEC_BASE,
	parameter logic [15:0]                                       VEC_STEP  = tli_pkg::VEC_STEP,
	parameter logic [31:0]                                       AUTO_CLR  = tli_pkg::AUTO_CLR,
	parameter logic [tli_pkg::MAX_SRC*tli_pkg::IDX_W-1:0] ORDER     = tli_pkg::identity_order()
) (
	// Clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      reset_n,

	// Register port
	input  wire logic [7:0]                reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [31:0]               reg_rdata,

	// Peripheral and pin interrupt events
	input  wire logic [N-1:0]              src_event,

	// CPU core side
	input  wire logic                      instr_done,
	input  wire logic                      return_from_irq_instruction_done,
	output logic                           irq_req,
	output logic                           irq_call,
	output logic      [15:0]               irq_vector,
	output logic      [tli_pkg::IDX_W-1:0] irq_src,
	output logic                           irq_high,
	output logic      [1:0]                isr_level
);

	localparam int IW  = tli_pkg::IDX_W;
	localparam int EXT = N - tli_pkg::LOW_EN_BITS;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Vector address of a source, used for the held vector
	function automatic logic [15:0] vec_of(input logic [IW-1:0] idx);
		logic [15:0] v;
		v = VEC_BASE + 16'(idx) * VEC_STEP;
		return v;
	endfunction : vec_of

	// Register hit test used by the write decoder
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	////////////////////////////////////////////////////////////////////////////////
	// State

	logic                 glb_en_q;    // global_irq_enable
	logic [N-1:0]         en_q;        // per-source enables
	logic [N-1:0]         prio_q;      // one means high level
	logic [N-1:0]         pend_q;      // pending flags
	logic [N-1:0]         pend_d;
	logic [1:0]           isr_q;       // bit 0 low, bit 1 high in service
	logic [1:0]           isr_d;
	logic                 req_q;
	logic                 req_d;
	logic                 call_q;
	logic [IW-1:0]        src_q;
	logic                 high_q;
	logic [15:0]          vec_q;
	logic [31:0]          rdata_q;
	logic [31:0]          rdata_d;
	logic [N-1:0]         elig;
	logic                 take;

	tli_arb_if #(.N(N)) arb_bus ();

	////////////////////////////////////////////////////////////////////////////////
	// Write decode

	logic wr_en;
	logic wr_ext_en;
	logic wr_prio;
	logic wr_ext_prio;
	logic wr_pend;

	assign wr_en       = reg_wr & hit(reg_addr, tli_pkg::OFS_ENABLE);
	assign wr_ext_en   = reg_wr & hit(reg_addr, tli_pkg::OFS_EXT_EN);
	assign wr_prio     = reg_wr & hit(reg_addr, tli_pkg::OFS_PRIO);
	assign wr_ext_prio = reg_wr & hit(reg_addr, tli_pkg::OFS_EXT_PRIO);
	assign wr_pend     = reg_wr & hit(reg_addr, tli_pkg::OFS_PENDING);

	////////////////////////////////////////////////////////////////////////////////
	// Enable register: low sources plus global enable in bit 7

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			glb_en_q <= tli_pkg::RST_BIT;
		end else if (wr_en) begin
			glb_en_q <= reg_wdata[tli_pkg::GLOBAL_EN_BIT];
		end
	end

	// Per-source enable bits, split over two registers
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			en_q <= N'(tli_pkg::RST_MASK);
		end else begin
			if (wr_en) begin
				en_q[tli_pkg::LOW_EN_BITS-1:0] <= reg_wdata[tli_pkg::LOW_EN_BITS-1:0];
			end
			if (wr_ext_en) begin
				en_q[N-1:tli_pkg::LOW_EN_BITS] <= reg_wdata[EXT-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Priority bits, same split as the enables; reset puts all at low

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			prio_q <= N'(tli_pkg::RST_MASK);
		end else begin
			if (wr_prio) begin
				prio_q[tli_pkg::LOW_EN_BITS-1:0] <= reg_wdata[tli_pkg::LOW_EN_BITS-1:0];
			end
			if (wr_ext_prio) begin
				prio_q[N-1:tli_pkg::LOW_EN_BITS] <= reg_wdata[EXT-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pending flags
	// Order matters: auto clear, then software write, then events, so that a
	// set of either kind in the same cycle as any clear is never lost.

	always_comb begin
		pend_d = pend_q;
		if (take && AUTO_CLR[src_q]) begin
			pend_d[src_q] = 1'b0;
		end
		if (wr_pend) begin
			// Writing one looks to the rest of the logic just like an event
			pend_d = reg_wdata[N-1:0];
		end
		// Set regardless of enables; disabled flags simply wait
		pend_d = pend_d | src_event;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pend_q <= N'(tli_pkg::RST_MASK);
		end else begin
			pend_q <= pend_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Eligibility
	// A flag counts only with its own enable and the global enable. Nesting
	// masks: nothing passes under a high routine, only high under a low one.
	// Masks follow the next in-service state: a return frees the request at
	// once, so only one instruction runs before re-entry.

	always_comb begin
		elig = pend_q & en_q & {N{glb_en_q}};
		if (isr_d[1]) begin
			elig = '0;
		end else if (isr_d[0]) begin
			elig = elig & prio_q;
		end
	end

	assign arb_bus.elig = elig;
	assign arb_bus.high = prio_q;

	tli_arbiter #(
		.N     (N),
		.ORDER (ORDER)
	) u_arb (
		.a (arb_bus.arb)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Request sampling
	// The winner is resampled every cycle except the take cycle; the one-cycle register is the
	// detect stage of the response time.

	// The return instruction's own boundary never takes, so one more
	// instruction always runs before re-entry.
	assign take = instr_done & req_q & ~return_from_irq_instruction_done;

	// Drop the request in the take cycle; in-service updates in the same cycle
	assign req_d = arb_bus.found & ~take;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			req_q <= tli_pkg::RST_BIT;
		end else begin
			req_q <= req_d;
		end
	end

	// Winner identity, level and vector travel with the request
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			src_q  <= '0;
			high_q <= tli_pkg::RST_BIT;
			vec_q  <= VEC_BASE;
		end else if (!take) begin
			src_q  <= arb_bus.idx;
			high_q <= arb_bus.win_high;
			vec_q  <= vec_of(arb_bus.idx);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Long call strobe
	// One-cycle pulse after the instruction boundary; the CPU then runs the
	// long_call_instruction to the held vector.

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			call_q <= tli_pkg::RST_BIT;
		end else begin
			call_q <= take;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Nesting levels
	// The return_from_irq_instruction retires the highest open level, so a
	// pre-empted low routine picks up again after the high one ends.

	always_comb begin
		isr_d = isr_q;
		if (take) begin
			if (high_q) begin
				isr_d[1] = 1'b1;
			end else begin
				isr_d[0] = 1'b1;
			end
		end else if (return_from_irq_instruction_done) begin
			if (isr_q[1]) begin
				isr_d[1] = 1'b0;
			end else begin
				isr_d[0] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			isr_q <= 2'h0;
		end else begin
			isr_q <= isr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read decode
	// Data stand for the one cycle after the strobe and read zero otherwise;
	// unmapped offsets also read zero.

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				tli_pkg::OFS_ENABLE: begin
					rdata_d[tli_pkg::GLOBAL_EN_BIT]         = glb_en_q;
					rdata_d[tli_pkg::LOW_EN_BITS-1:0]       = en_q[tli_pkg::LOW_EN_BITS-1:0];
				end
				tli_pkg::OFS_EXT_EN: begin
					rdata_d[EXT-1:0] = en_q[N-1:tli_pkg::LOW_EN_BITS];
				end
				tli_pkg::OFS_PRIO: begin
					rdata_d[tli_pkg::LOW_EN_BITS-1:0] = prio_q[tli_pkg::LOW_EN_BITS-1:0];
				end
				tli_pkg::OFS_EXT_PRIO: begin
					rdata_d[EXT-1:0] = prio_q[N-1:tli_pkg::LOW_EN_BITS];
				end
				tli_pkg::OFS_PENDING: begin
					rdata_d[N-1:0] = pend_q;
				end
				tli_pkg::OFS_STATUS: begin
					rdata_d[tli_pkg::ST_ISR_LOW]                = isr_q[0];
					rdata_d[tli_pkg::ST_ISR_HIGH]               = isr_q[1];
					rdata_d[tli_pkg::ST_REQ]                    = req_q;
					rdata_d[tli_pkg::ST_SRC_LSB +: IW]          = src_q;
				end
				default: begin
					rdata_d = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops

	assign reg_rdata  = rdata_q;
	assign irq_req    = req_q;
	assign irq_call   = call_q;
	assign irq_vector = vec_q;
	assign irq_src    = src_q;
	assign irq_high   = high_q;
	assign isr_level  = isr_q;

endmodule : tli_handler
`default_nettype wire

/* tb/tli_handler_asserts.sv */
// Port-level checks on the interrupt handler
`timescale 1ns/100ps
`default_nettype none
module tli_handler_asserts #(
	parameter logic [15:0] VEC_BASE = tli_pkg::VEC_BASE,
	parameter logic [15:0] VEC_STEP = tli_pkg::VEC_STEP
) (
	// Clock and reset
	input wire logic                      clk_sys,
	input wire logic                      reset_n,
	// CPU side
	input wire logic                      instr_done,
	input wire logic                      return_from_irq_instruction_done,
	input wire logic                      irq_req,
	input wire logic                      irq_call,
	input wire logic [15:0]               irq_vector,
	input wire logic [tli_pkg::IDX_W-1:0] irq_src,
	input wire logic                      irq_high,
	input wire logic [1:0]                isr_level
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////////
	// Steps of a take and of a return at an instruction boundary
	sequence take_s;
		irq_req && instr_done && !return_from_irq_instruction_done;
	endsequence
	sequence ret_s;
		instr_done && return_from_irq_instruction_done;
	endsequence
	call_after_take_a: assert property (take_s |=> irq_call && !irq_req)
		else $error("no call after take");
	call_pulse_a: assert property (irq_call |=> !irq_call)
		else $error("call longer than one cycle");
	call_cause_a: assert property (irq_call |-> $past(instr_done) && !$past(return_from_irq_instruction_done))
		else $error("call without plain boundary");
	vector_map_a: assert property (irq_req |-> irq_vector == VEC_BASE + VEC_STEP * 16'(irq_src))
		else $error("vector does not match source");
	high_blocks_a: assert property (isr_level[1] |=> !irq_call)
		else $error("call under high routine");
	preempt_level_a: assert property (irq_call && $past(isr_level) == 2'b01 |-> isr_level == 2'b11)
		else $error("low routine entered by low");
	enter_level_a: assert property (irq_call && $past(isr_level) == 2'b00 |->
		isr_level == ($past(irq_high) ? 2'b10 : 2'b01))
		else $error("wrong level on entry");
	return_from_irq_instruction_high_a: assert property (ret_s ##0 isr_level[1] |=> isr_level == {1'b0, $past(isr_level[0])})
		else $error("high level not closed");
	return_from_irq_instruction_low_a: assert property (ret_s ##0 isr_level == 2'b01 |=> isr_level == 2'b00)
		else $error("low level not closed");
	return_from_irq_instruction_no_call_a: assert property (ret_s |=> !irq_call)
		else $error("call on return boundary");
endmodule : tli_handler_asserts

bind tli_handler tli_handler_asserts #(.VEC_BASE(VEC_BASE), .VEC_STEP(VEC_STEP)) u_asserts (
	.clk_sys(clk_sys), .reset_n(reset_n), .instr_done(instr_done), .return_from_irq_instruction_done(return_from_irq_instruction_done),
	.irq_req(irq_req), .irq_call(irq_call), .irq_vector(irq_vector), .irq_src(irq_src),
	.irq_high(irq_high), .isr_level(isr_level));
`default_nettype wire

/* tb/tli_cpu_model.sv */
// Behavioural CPU core pacing instructions and answering long calls
`timescale 1ns/100ps
`default_nettype none
module tli_cpu_model (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// Handler side
	input  wire logic       irq_call,
	output logic            instr_done,
	output logic            return_from_irq_instruction_done,
	// Bench control
	input  wire logic [3:0] gap,
	input  wire logic       return_from_irq_instruction_go
);
	logic [3:0] cnt_q;
	logic       pend_q;
	int         depth_q;
	logic       bound;
	logic       ret;
	////////////////////////////////////////////////////////////////////////////
	// Boundary once the gap runs out; a call in flight stalls the pipe
	assign bound = (cnt_q >= gap) && !irq_call;
	// Return only from inside a routine
	assign ret = bound && pend_q && depth_q > 0;
	// Pacing, call nesting and return bookkeeping
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			cnt_q      <= 4'h0;
			pend_q     <= 1'b0;
			depth_q    <= 0;
			instr_done <= 1'b0;
			return_from_irq_instruction_done  <= 1'b0;
		end else begin
			instr_done <= bound;
			return_from_irq_instruction_done  <= ret;
			cnt_q      <= (bound || irq_call) ? 4'h0 : cnt_q + 4'h1;
			pend_q     <= return_from_irq_instruction_go || (pend_q && !ret);
			// Every call lands in a valid routine
			depth_q    <= depth_q + (irq_call ? 1 : 0) - (ret ? 1 : 0);
		end
	end
endmodule : tli_cpu_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the two-level interrupt handler
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module testbench;
	localparam int         N    = tli_pkg::NUM_SRC;
	localparam logic [7:0] PEND = tli_pkg::OFS_PENDING;
	localparam logic [7:0] EN   = tli_pkg::OFS_ENABLE;
	// Design and model signals
	logic        clk_sys   = 1'b0;
	logic        reset_n   = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [31:0] reg_rdata;
	logic [N-1:0] src_event = '0;
	logic        instr_done, return_from_irq_instruction_done, irq_req, irq_call, irq_high;
	logic [15:0] irq_vector;
	logic [4:0]  irq_src;
	logic [1:0]  isr_level;
	logic [3:0]  gap       = 4'h2;
	logic        return_from_irq_instruction_go   = 1'b0;
	int          icnt      = 0;
	int          errors    = 0;
	int          checks    = 0;
	int          last_wait = 0;
	////////////////////////////////////////////////////////////////////////////
	always #50 clk_sys = ~clk_sys;
	tli_handler DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.src_event(src_event), .instr_done(instr_done), .return_from_irq_instruction_done(return_from_irq_instruction_done),
		.irq_req(irq_req), .irq_call(irq_call), .irq_vector(irq_vector), .irq_src(irq_src),
		.irq_high(irq_high), .isr_level(isr_level));
	tli_cpu_model u_cpu (.clk_sys(clk_sys), .reset_n(reset_n), .irq_call(irq_call),
		.instr_done(instr_done), .return_from_irq_instruction_done(return_from_irq_instruction_done), .gap(gap), .return_from_irq_instruction_go(return_from_irq_instruction_go));
	// Instructions finished since the last return
	always @(posedge clk_sys) begin
		if (return_from_irq_instruction_done)
			icnt <= 0;
		else if (instr_done)
			icnt <= icnt + 1;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		@(negedge clk_sys);
		`CHK(reg_rdata, e)
		// Read data stand for one cycle only
		@(negedge clk_sys);
		`CHK(reg_rdata, 32'h0)
	endtask : rd
	// Bounded wait for a call, then check its vector
	task automatic wait_call(input int s);
		int k;
		k = 0;
		@(negedge clk_sys);
		while (irq_call !== 1'b1 && k < 300) begin
			@(negedge clk_sys);
			k++;
		end
		last_wait = k;
		if (k >= 300) begin
			errors++;
			give_verdict();
		end
		`CHK(irq_vector, tli_pkg::VEC_BASE + tli_pkg::VEC_STEP * 16'(s))
	endtask : wait_call
	task automatic no_call(input int n);
		repeat (n) begin
			@(negedge clk_sys);
			`CHK(irq_call, 1'b0)
		end
	endtask : no_call
	// Ask the core to return and wait until the level has moved
	task automatic do_return_from_irq_instruction();
		int k;
		k = 0;
		@(posedge clk_sys);
		return_from_irq_instruction_go <= 1'b1;
		@(posedge clk_sys);
		return_from_irq_instruction_go <= 1'b0;
		while (return_from_irq_instruction_done !== 1'b1 && k < 100) begin
			@(negedge clk_sys);
			k++;
		end
		if (k >= 100) begin
			errors++;
			give_verdict();
		end
		@(negedge clk_sys);
	endtask : do_return_from_irq_instruction
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0);
		$display("test reset values done");
		// Events while globally disabled stay pending
		@(posedge clk_sys);
		src_event <= N'(3);
		@(posedge clk_sys);
		src_event <= '0;
		wr(EN, 32'h02);
		no_call(8);
		rd(PEND, 32'h3);
		wr(EN, 32'h82);
		wait_call(1);
		`CHK(isr_level, 2'b01)
		do_return_from_irq_instruction();
		rd(PEND, 32'h1);
		no_call(8);
		wr(PEND, 32'h0);
		$display("test global enable done");
		// Software set, flag left set, back-to-back boundaries
		gap <= 4'h0;
		wr(EN, 32'ha0);
		wr(PEND, 32'h20);
		wait_call(5);
		`CHK(last_wait, 2)
		rd(PEND, 32'h20);
		do_return_from_irq_instruction();
		wait_call(5);
		`CHK(icnt, 1)
		wr(PEND, 32'h0);
		do_return_from_irq_instruction();
		`CHK(isr_level, 2'b00)
		gap <= 4'h2;
		$display("test re-entry done");
		// Nesting of a high routine inside a low one
		wr(EN, 32'hd8);
		wr(tli_pkg::OFS_PRIO, 32'h40);
		rd(tli_pkg::OFS_PRIO, 32'h40);
		wr(PEND, 32'h10);
		wait_call(4);
		wr(PEND, 32'h50);
		wait_call(6);
		`CHK(isr_level, 2'b11)
		wr(PEND, 32'h58);
		no_call(12);
		wr(PEND, 32'h18);
		do_return_from_irq_instruction();
		`CHK(isr_level, 2'b01)
		no_call(12);
		wr(PEND, 32'h08);
		do_return_from_irq_instruction();
		wait_call(3);
		rd(PEND, 32'h0);
		do_return_from_irq_instruction();
		$display("test nesting done");
		// Simultaneous requests on both levels
		wr(EN, 32'h84);
		wr(tli_pkg::OFS_PRIO, 32'h0);
		wr(tli_pkg::OFS_EXT_EN, 32'h18);
		wr(tli_pkg::OFS_EXT_PRIO, 32'h18);
		wr(PEND, 32'h0c04);
		wait_call(10);
		`CHK(isr_level, 2'b10)
		wr(PEND, 32'h0804);
		do_return_from_irq_instruction();
		wait_call(11);
		wr(PEND, 32'h0004);
		do_return_from_irq_instruction();
		wait_call(2);
		do_return_from_irq_instruction();
		`CHK(isr_level, 2'b00)
		$display("test arbitration done");
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
